// File: logic/dma_crc_generator_regs.sv
/*
 * DMA checksum generator: AXI4-Lite register front end, data word intake
 * from a DMA channel, and the checksum engine instance.
 * Assumes the DMA channel keeps dma_valid and dma_data steady until dma_ready,
 * and that the bus master keeps AXI4-Lite valid/ready rules.
 */
// Chosen here: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "crc_defines.svh"
module dma_crc_generator_regs #(
	parameter int ADDR_W = 8,
	parameter int DATA_W = 32
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// axi4-lite write address
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	// axi4-lite write data
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	// axi4-lite write response
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// axi4-lite read address
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	// axi4-lite read data
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// dma data words
	input wire logic dma_valid,
	input wire logic [DATA_W-1:0] dma_data,
	output logic dma_ready
);

	// ----------------------------------------------------------------------
	// functions
	// ----------------------------------------------------------------------
	function automatic crc_pkg::reg_sel_t decode(input logic [ADDR_W-1:0] addr);
		logic [ADDR_W-1:0] word;
		word = {addr[ADDR_W-1:2], 2'b00};
		if (word == ADDR_W'(`CSUM_VALUE_OFFSET)) begin
			return crc_pkg::SEL_VALUE;
		end else if (word == ADDR_W'(`TAP_MASK_OFFSET)) begin
			return crc_pkg::SEL_MASK;
		end else if (word == ADDR_W'(`CSUM_CTRL_OFFSET)) begin
			return crc_pkg::SEL_CTRL;
		end else if (word == ADDR_W'(`CSUM_STATUS_OFFSET)) begin
			return crc_pkg::SEL_STATUS;
		end else begin
			return crc_pkg::SEL_NONE;
		end
	endfunction

	function automatic logic [31:0] apply_strobe(input logic [31:0] old,
			input logic [31:0] data, input logic [3:0] strb);
		logic [31:0] m;
		m = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				m[b*8 +: 8] = data[b*8 +: 8];
			end
		end
		return m;
	endfunction

	// ----------------------------------------------------------------------
	// engine
	// ----------------------------------------------------------------------
	crc_feed_if #(.DATA_W(DATA_W)) feed ();

	crc_engine #(.DATA_W(DATA_W)) engine (
		.ref_clk(ref_clk),
		.rst(rst),
		.port(feed.engine)
	);

	// ----------------------------------------------------------------------
	// configuration state
	// ----------------------------------------------------------------------
	logic ctrl_type;
	logic next_ctrl_type;
	logic [4:0] ctrl_polynomial_length;
	logic [4:0] next_ctrl_polynomial_length;
	logic [31:0] tap_mask;
	logic [31:0] next_tap_mask;
	logic [31:0] value_view;
	logic [31:0] ctrl_word;
	logic [31:0] status_word;

	assign feed.mode_ip = ctrl_type;
	assign feed.poly_len = ctrl_polynomial_length;
	assign feed.tap_mask = tap_mask;
	assign feed.word_valid = dma_valid;
	assign feed.word_data = dma_data;
	assign dma_ready = feed.word_ready;

	// the engine keeps the raw sum; software sees it inverted in IP mode
	always_comb begin
		if (ctrl_type) begin
			value_view = {16'h0000, ~feed.result[15:0]};
		end else begin
			value_view = feed.result & crc_pkg::len_mask(ctrl_polynomial_length);
		end
	end

	always_comb begin
		ctrl_word = 32'h00000000;
		ctrl_word[`CTRL_TYPE_BIT] = ctrl_type;
		ctrl_word[`CTRL_POLYNOMIAL_LENGTH_MSB:`CTRL_POLYNOMIAL_LENGTH_LSB] = ctrl_polynomial_length;
		status_word = 32'h00000000;
		status_word[`STATUS_BUSY_BIT] = feed.busy;
	end

	// ----------------------------------------------------------------------
	// write channel
	// ----------------------------------------------------------------------
	crc_pkg::wr_state_t wr_state;
	crc_pkg::wr_state_t next_wr_state;
	logic aw_held;
	logic next_aw_held;
	logic [ADDR_W-1:0] aw_addr;
	logic [ADDR_W-1:0] next_aw_addr;
	logic w_held;
	logic next_w_held;
	logic [31:0] w_data;
	logic [31:0] next_w_data;
	logic [3:0] w_strb;
	logic [3:0] next_w_strb;
	logic [1:0] next_bresp;
	logic [31:0] merged;
	crc_pkg::reg_sel_t wr_sel;

	// address and data are taken independently, in either order
	assign awready = (wr_state == crc_pkg::WR_IDLE) && !aw_held;
	assign wready = (wr_state == crc_pkg::WR_IDLE) && !w_held;
	assign bvalid = (wr_state == crc_pkg::WR_RESP);

	always_comb begin
		next_wr_state = wr_state;
		next_aw_held = aw_held;
		next_aw_addr = aw_addr;
		next_w_held = w_held;
		next_w_data = w_data;
		next_w_strb = w_strb;
		next_bresp = bresp;
		next_ctrl_type = ctrl_type;
		next_ctrl_polynomial_length = ctrl_polynomial_length;
		next_tap_mask = tap_mask;
		feed.seed_load = 1'b0;
		feed.seed_value = 32'h00000000;
		merged = 32'h00000000;
		wr_sel = decode(aw_addr);
		case (wr_state)
			crc_pkg::WR_IDLE: begin
				if (awvalid && awready) begin
					next_aw_held = 1'b1;
					next_aw_addr = awaddr;
				end
				if (wvalid && wready) begin
					next_w_held = 1'b1;
					next_w_data = wdata;
					next_w_strb = wstrb;
				end
				if (aw_held && w_held) begin
					next_aw_held = 1'b0;
					next_w_held = 1'b0;
					next_wr_state = crc_pkg::WR_RESP;
					next_bresp = `AXI_RESP_OKAY;
					if (wr_sel == crc_pkg::SEL_VALUE) begin
						merged = apply_strobe(value_view, w_data, w_strb);
						feed.seed_load = 1'b1;
						if (ctrl_type) begin
							feed.seed_value = {16'h0000, ~merged[15:0]};
						end else begin
							feed.seed_value = merged & crc_pkg::len_mask(ctrl_polynomial_length);
						end
					end else if (wr_sel == crc_pkg::SEL_MASK) begin
						next_tap_mask = apply_strobe(tap_mask, w_data, w_strb);
					end else if (wr_sel == crc_pkg::SEL_CTRL) begin
						merged = apply_strobe(ctrl_word, w_data, w_strb);
						next_ctrl_type = merged[`CTRL_TYPE_BIT];
						next_ctrl_polynomial_length = merged[`CTRL_POLYNOMIAL_LENGTH_MSB:`CTRL_POLYNOMIAL_LENGTH_LSB];
					end else if (wr_sel == crc_pkg::SEL_STATUS) begin
						// read-only: write accepted and dropped
						next_bresp = `AXI_RESP_OKAY;
					end else begin
						next_bresp = `AXI_RESP_SLVERR;
					end
				end
			end
			crc_pkg::WR_RESP: begin
				if (bready) begin
					next_wr_state = crc_pkg::WR_IDLE;
				end
			end
			default: begin
				next_wr_state = crc_pkg::WR_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			wr_state <= crc_pkg::WR_IDLE;
			aw_held <= 1'b0;
			aw_addr <= '0;
			w_held <= 1'b0;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
			bresp <= `AXI_RESP_OKAY;
			ctrl_type <= `CTRL_TYPE_RESET;
			ctrl_polynomial_length <= `CTRL_POLYNOMIAL_LENGTH_RESET;
			tap_mask <= `TAP_MASK_RESET;
		end else begin
			wr_state <= next_wr_state;
			aw_held <= next_aw_held;
			aw_addr <= next_aw_addr;
			w_held <= next_w_held;
			w_data <= next_w_data;
			w_strb <= next_w_strb;
			bresp <= next_bresp;
			ctrl_type <= next_ctrl_type;
			ctrl_polynomial_length <= next_ctrl_polynomial_length;
			tap_mask <= next_tap_mask;
		end
	end

	// ----------------------------------------------------------------------
	// read channel
	// ----------------------------------------------------------------------
	crc_pkg::rd_state_t rd_state;
	crc_pkg::rd_state_t next_rd_state;
	logic [31:0] next_rdata;
	logic [1:0] next_rresp;
	crc_pkg::reg_sel_t rd_sel;

	assign arready = (rd_state == crc_pkg::RD_IDLE);
	assign rvalid = (rd_state == crc_pkg::RD_DATA);

	// data is captured at the address edge, so a later engine step does not
	// change a word that is already waiting for rready
	always_comb begin
		next_rd_state = rd_state;
		next_rdata = rdata;
		next_rresp = rresp;
		rd_sel = decode(araddr);
		case (rd_state)
			crc_pkg::RD_IDLE: begin
				if (arvalid) begin
					next_rd_state = crc_pkg::RD_DATA;
					next_rresp = `AXI_RESP_OKAY;
					if (rd_sel == crc_pkg::SEL_VALUE) begin
						next_rdata = value_view;
					end else if (rd_sel == crc_pkg::SEL_MASK) begin
						next_rdata = tap_mask;
					end else if (rd_sel == crc_pkg::SEL_CTRL) begin
						next_rdata = ctrl_word;
					end else if (rd_sel == crc_pkg::SEL_STATUS) begin
						next_rdata = status_word;
					end else begin
						next_rdata = 32'h00000000;
						next_rresp = `AXI_RESP_SLVERR;
					end
				end
			end
			crc_pkg::RD_DATA: begin
				if (rready) begin
					next_rd_state = crc_pkg::RD_IDLE;
				end
			end
			default: begin
				next_rd_state = crc_pkg::RD_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			rd_state <= crc_pkg::RD_IDLE;
			rdata <= 32'h00000000;
			rresp <= `AXI_RESP_OKAY;
		end else begin
			rd_state <= next_rd_state;
			rdata <= next_rdata;
			rresp <= next_rresp;
		end
	end

endmodule

// File: logic/crc_defines.svh
/*
 * Register map, field positions, reset values and bus answer codes of the
 * DMA checksum generator.
 * Assumes it is included by its bare name and that nothing else defines these macros.
 */
`ifndef CRC_DEFINES_SVH
`define CRC_DEFINES_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define CSUM_VALUE_OFFSET 8'h00
`define TAP_MASK_OFFSET 8'h04
`define CSUM_CTRL_OFFSET 8'h08
`define CSUM_STATUS_OFFSET 8'h0C

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define CTRL_TYPE_BIT 15
`define CTRL_POLYNOMIAL_LENGTH_MSB 4
`define CTRL_POLYNOMIAL_LENGTH_LSB 0
`define STATUS_BUSY_BIT 0

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define CSUM_VALUE_RESET 32'h00000000
`define TAP_MASK_RESET 32'h00000000
`define CTRL_TYPE_RESET 1'b0
`define CTRL_POLYNOMIAL_LENGTH_RESET 5'h00

// ----------------------------------------------------------------------
// axi answer codes
// ----------------------------------------------------------------------
`define AXI_RESP_OKAY 2'b00
`define AXI_RESP_SLVERR 2'b10

`endif

// File: logic/crc_pkg.sv
/*
 * Types and shared helper functions of the DMA checksum generator.
 * Assumes the 32-bit checksum register width is fixed.
 */
package crc_pkg;

	// ----------------------------------------------------------------------
	// state and decode types
	// ----------------------------------------------------------------------
	typedef enum logic [1:0] {
		ENG_IDLE = 2'b01,
		ENG_SHIFT = 2'b10
	} engine_state_t;

	typedef enum logic [1:0] {
		WR_IDLE = 2'b01,
		WR_RESP = 2'b10
	} wr_state_t;

	typedef enum logic [1:0] {
		RD_IDLE = 2'b01,
		RD_DATA = 2'b10
	} rd_state_t;

	typedef enum logic [4:0] {
		SEL_NONE = 5'b00001,
		SEL_VALUE = 5'b00010,
		SEL_MASK = 5'b00100,
		SEL_CTRL = 5'b01000,
		SEL_STATUS = 5'b10000
	} reg_sel_t;

	// ----------------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------------
	// ones in bit positions 0 up to and including polynomial_length
	function automatic logic [31:0] len_mask(input logic [4:0] polynomial_length);
		return 32'hFFFFFFFF >> (5'h1F - polynomial_length);
	endfunction

endpackage

// File: logic/crc_feed_if.sv
/*
 * Carrier between the register front end and the checksum engine.
 * Assumes both ends share one clock and reset.
 */
`timescale 1ns/1ps
interface crc_feed_if #(parameter int DATA_W = 32);
	logic mode_ip;
	logic [4:0] poly_len;
	logic [31:0] tap_mask;
	logic seed_load;
	logic [31:0] seed_value;
	logic word_valid;
	logic word_ready;
	logic [DATA_W-1:0] word_data;
	logic [31:0] result;
	logic busy;

	modport ctrl (
		output mode_ip, poly_len, tap_mask, seed_load, seed_value, word_valid, word_data,
		input word_ready, result, busy
	);
	modport engine (
		input mode_ip, poly_len, tap_mask, seed_load, seed_value, word_valid, word_data,
		output word_ready, result, busy
	);
endinterface

// File: logic/crc_engine.sv
/*
 * Checksum engine: LFSR CRC shifted one data bit per clock, or an IP-header
 * ones'-complement sum folded in one clock per word.
 * Assumes the seed it receives is already converted for the current mode.
 */
`timescale 1ns/1ps
`include "crc_defines.svh"
module crc_engine #(
	parameter int DATA_W = 32
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// front end
	crc_feed_if.engine port
);
	localparam int CNT_W = $clog2(DATA_W) + 1;

	crc_pkg::engine_state_t state;
	crc_pkg::engine_state_t next_state;
	logic [31:0] result;
	logic [31:0] next_result;
	logic [DATA_W-1:0] shift_reg;
	logic [DATA_W-1:0] next_shift_reg;
	logic [CNT_W-1:0] bit_cnt;
	logic [CNT_W-1:0] next_bit_cnt;
	logic take_word;

	// ----------------------------------------------------------------------
	// functions
	// ----------------------------------------------------------------------
	// stage 0 has no predecessor, so it always takes the feedback term
	function automatic logic [31:0] lfsr_step(input logic [31:0] crc, input logic din,
			input logic [31:0] mask, input logic [4:0] polynomial_length);
		logic fb;
		logic [31:0] nxt;
		fb = crc[polynomial_length] ^ din;
		nxt[0] = fb;
		for (int i = 1; i < 32; i++) begin
			nxt[i] = crc[i-1] ^ (mask[i] & fb);
		end
		return nxt & crc_pkg::len_mask(polynomial_length);
	endfunction

	function automatic logic [15:0] ones_add(input logic [15:0] a, input logic [15:0] b);
		logic [16:0] s;
		s = {1'b0, a} + {1'b0, b};
		return s[15:0] + {15'h0000, s[16]};
	endfunction

	// ----------------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------------
	assign take_word = port.word_valid && port.word_ready;
	// a seed write wins over a data word offered in the same cycle
	assign port.word_ready = (state == crc_pkg::ENG_IDLE) && !port.seed_load;
	assign port.busy = (state != crc_pkg::ENG_IDLE);
	assign port.result = result;

	always_comb begin
		next_state = state;
		next_result = result;
		next_shift_reg = shift_reg;
		next_bit_cnt = bit_cnt;
		case (state)
			crc_pkg::ENG_IDLE: begin
				if (port.seed_load) begin
					next_result = port.seed_value;
				end else if (take_word && port.mode_ip) begin
					// tap mask is never consulted on this path
					for (int h = DATA_W / 16 - 1; h >= 0; h--) begin
						next_result = {16'h0000, ones_add(next_result[15:0],
							port.word_data[h*16 +: 16])};
					end
				end else if (take_word) begin
					next_shift_reg = port.word_data;
					next_bit_cnt = CNT_W'(DATA_W);
					next_state = crc_pkg::ENG_SHIFT;
				end
			end
			crc_pkg::ENG_SHIFT: begin
				if (port.seed_load) begin
					next_result = port.seed_value;
					next_state = crc_pkg::ENG_IDLE;
				end else begin
					// msb first, one bit per clock
					next_result = lfsr_step(result, shift_reg[DATA_W-1], port.tap_mask,
						port.poly_len);
					next_shift_reg = {shift_reg[DATA_W-2:0], 1'b0};
					next_bit_cnt = bit_cnt - CNT_W'(1);
					if (bit_cnt == CNT_W'(1)) begin
						next_state = crc_pkg::ENG_IDLE;
					end
				end
			end
			default: begin
				next_state = crc_pkg::ENG_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state <= crc_pkg::ENG_IDLE;
			result <= `CSUM_VALUE_RESET;
			shift_reg <= '0;
			bit_cnt <= '0;
		end else begin
			state <= next_state;
			result <= next_result;
			shift_reg <= next_shift_reg;
			bit_cnt <= next_bit_cnt;
		end
	end

endmodule

// File: verification/dma_crc_chk.sv
/* port checker for the dma checksum generator.
 * assumes it is bound into dma_crc_generator_regs with one clock. */
`timescale 1ns/1ps
`include "crc_defines.svh"
module dma_crc_chk #(
	parameter int ADDR_W = 8,
	parameter int DATA_W = 32
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// register bus
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic bvalid,
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic rvalid,
	input wire logic rready,
	// dma words
	input wire logic dma_ready
);
	// ------------------------------
	// stall length counter
	// ------------------------------
	int low_cnt;
	int next_low_cnt;
	always_comb begin
		next_low_cnt = dma_ready ? 0 : low_cnt + 1;
	end
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			low_cnt <= 0;
		end else begin
			low_cnt <= next_low_cnt;
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	sequence s_resp;
		!bvalid ##1 bvalid;
	endsequence
	sequence s_both_taken;
		awvalid && awready && wvalid && wready;
	endsequence

	wr_resp_a: assert property (s_both_taken |=> s_resp)
		else $error("write answer not two cycles after take");
	one_write_a: assert property (bvalid |-> !awready && !wready)
		else $error("write accepted while answer pending");
	rd_resp_a: assert property (arvalid && arready |=> rvalid)
		else $error("read answer late");
	rhold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read data dropped before ready");
	one_read_a: assert property (rvalid |-> !arready)
		else $error("read accepted while answer pending");
	unmapped_rd_a: assert property (arvalid && arready && araddr >= 16 |=>
		rvalid && rresp == `AXI_RESP_SLVERR && rdata == 32'h00000000)
		else $error("unmapped read not refused");
	reset_idle_a: assert property ($fell(rst) |-> awready && wready && arready
		&& dma_ready && !bvalid && !rvalid)
		else $error("outputs not idle after reset");
	stall_len_a: assert property ($rose(dma_ready) && low_cnt > 1 |-> low_cnt == DATA_W)
		else $error("shift stall not one cycle per bit");
endmodule

bind dma_crc_generator_regs dma_crc_chk #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) chk (
	.ref_clk(ref_clk), .rst(rst), .awvalid(awvalid), .awready(awready),
	.wvalid(wvalid), .wready(wready), .bvalid(bvalid), .araddr(araddr),
	.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
	.rvalid(rvalid), .rready(rready), .dma_ready(dma_ready)
);

// File: verification/dma_feeder.sv
/* model of the dma channel that feeds data words.
 * assumes the caller calls send just after a rising edge. */
`timescale 1ns/1ps
module dma_feeder (
	// clock
	input wire logic ref_clk,
	// word channel
	output logic dma_valid,
	output logic [31:0] dma_data,
	input wire logic dma_ready
);
	initial begin
		dma_valid = 1'b0;
		dma_data = 32'h00000000;
	end
	// more keeps valid up so the next word follows back to back
	task automatic send(input logic [31:0] w, input bit more);
		dma_valid <= 1'b1;
		dma_data <= w;
		do @(posedge ref_clk); while (dma_ready !== 1'b1);
		if (!more) begin
			dma_valid <= 1'b0;
			// released data never shows the last word
			dma_data <= ~w;
		end
	endtask
endmodule

// File: verification/tb_top.sv
/* self-checking bench for the dma checksum generator.
 * assumes the checker is bound and the feeder models the dma channel. */
`timescale 1ns/1ps
`include "crc_defines.svh"
module tb_top;
	logic ref_clk, rst, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, dma_valid, dma_ready;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, dma_data;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	int num_errors, total_checks;

	dma_crc_generator_regs dut (.ref_clk(ref_clk), .rst(rst), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
		.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.dma_valid(dma_valid), .dma_data(dma_data), .dma_ready(dma_ready));
	dma_feeder feeder (.ref_clk(ref_clk), .dma_valid(dma_valid), .dma_data(dma_data),
		.dma_ready(dma_ready));

	// ------------------------------
	// bus and compare tasks
	// ------------------------------
	task chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		bit ad, dd;
		ad = 0;
		dd = 0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (!(ad && dd)) begin
			@(posedge ref_clk);
			if (!ad && awready === 1'b1) begin
				ad = 1;
				awvalid <= 1'b0;
			end
			if (!dd && wready === 1'b1) begin
				dd = 1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge ref_clk); while (bvalid !== 1'b1);
		chk({30'h0, bresp}, {30'h0, er});
	endtask
	task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		araddr <= a;
		arvalid <= 1'b1;
		do @(posedge ref_clk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		// late ready makes the slave hold its answer
		@(posedge ref_clk);
		rready <= 1'b1;
		do @(posedge ref_clk); while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask
	task rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
		logic [31:0] d;
		logic [1:0] r;
		rd(a, d, r);
		chk(d, exp);
		chk({30'h0, r}, {30'h0, er});
	endtask
	task wait_idle;
		logic [31:0] d;
		logic [1:0] r;
		for (int n = 0; n < 40; n++) begin
			rd(`CSUM_STATUS_OFFSET, d, r);
			if (d[`STATUS_BUSY_BIT] === 1'b0) break;
		end
		chk({31'h0, d[`STATUS_BUSY_BIT]}, 32'h00000000);
	endtask

	// ------------------------------
	// reference models
	// ------------------------------
	function automatic logic [31:0] lfsr_ref(input logic [31:0] seed, mask, w,
		input int l);
		logic [31:0] c, n;
		logic fb;
		c = 32'h00000000;
		for (int j = 0; j <= l; j++) c[j] = seed[j];
		for (int i = 31; i >= 0; i--) begin
			fb = c[l] ^ w[i];
			n = 32'h00000000;
			n[0] = fb;
			for (int j = 1; j <= l; j++) n[j] = c[j-1] ^ (mask[j] & fb);
			c = n;
		end
		return c;
	endfunction
	function automatic logic [31:0] ip_ref(input logic [31:0] seed, w0, w1);
		logic [16:0] s;
		logic [15:0] acc;
		logic [15:0] hw[4];
		hw = '{w0[31:16], w0[15:0], w1[31:16], w1[15:0]};
		acc = ~seed[15:0];
		foreach (hw[i]) begin
			s = acc + hw[i];
			acc = s[15:0] + s[16];
		end
		return {16'h0000, ~acc};
	endfunction

	// ------------------------------
	// scenarios
	// ------------------------------
	task t_reset;
		rd_chk(`CSUM_VALUE_OFFSET, 32'h00000000, `AXI_RESP_OKAY);
		rd_chk(`TAP_MASK_OFFSET, 32'h00000000, `AXI_RESP_OKAY);
		rd_chk(8'h40, 32'h00000000, `AXI_RESP_SLVERR);
		wr(8'h40, 32'hFFFFFFFF, `AXI_RESP_SLVERR);
		wr(`CSUM_STATUS_OFFSET, 32'hFFFFFFFF, `AXI_RESP_OKAY);
		rd_chk(`CSUM_STATUS_OFFSET, 32'h00000000, `AXI_RESP_OKAY);
	endtask
	task t_regs;
		wr(`CSUM_CTRL_OFFSET, 32'h0000001F, `AXI_RESP_OKAY);
		wr(`CSUM_VALUE_OFFSET, 32'hDEADBEEF, `AXI_RESP_OKAY);
		rd_chk(`CSUM_VALUE_OFFSET, 32'hDEADBEEF, `AXI_RESP_OKAY);
		wr(`TAP_MASK_OFFSET, 32'hA5A55A5A, `AXI_RESP_OKAY);
		rd_chk(`TAP_MASK_OFFSET, 32'hA5A55A5A, `AXI_RESP_OKAY);
		// a single byte lane merges into the word already held
		wstrb <= 4'h1;
		wr(`TAP_MASK_OFFSET, 32'h000000FF, `AXI_RESP_OKAY);
		wstrb <= 4'hF;
		rd_chk(`TAP_MASK_OFFSET, 32'hA5A55AFF, `AXI_RESP_OKAY);
		wr(`CSUM_CTRL_OFFSET, 32'h00000007, `AXI_RESP_OKAY);
		rd_chk(`CSUM_CTRL_OFFSET, 32'h00000007, `AXI_RESP_OKAY);
		wr(`CSUM_VALUE_OFFSET, 32'h123456FF, `AXI_RESP_OKAY);
		rd_chk(`CSUM_VALUE_OFFSET, 32'h000000FF, `AXI_RESP_OKAY);
	endtask
	task t_lfsr;
		logic [31:0] mk[3], sd[3], wd[3];
		int ln[3];
		mk = '{32'h00001021, 32'h00000000, 32'h04C11DB7};
		sd = '{32'h0000FFFF, 32'h00000ABC, 32'hFFFFFFFF};
		wd = '{32'h31323334, 32'h80000001, 32'hC0FFEE00};
		ln = '{15, 11, 31};
		for (int k = 0; k < 3; k++) begin
			wr(`CSUM_CTRL_OFFSET, 32'(ln[k]), `AXI_RESP_OKAY);
			wr(`TAP_MASK_OFFSET, mk[k], `AXI_RESP_OKAY);
			wr(`CSUM_VALUE_OFFSET, sd[k], `AXI_RESP_OKAY);
			feeder.send(wd[k], 0);
			wait_idle();
			rd_chk(`CSUM_VALUE_OFFSET, lfsr_ref(sd[k], mk[k], wd[k], ln[k]),
				`AXI_RESP_OKAY);
		end
	endtask
	task t_ip;
		wr(`TAP_MASK_OFFSET, 32'hFFFFFFFF, `AXI_RESP_OKAY);
		wr(`CSUM_CTRL_OFFSET, 32'h00008000, `AXI_RESP_OKAY);
		rd_chk(`CSUM_CTRL_OFFSET, 32'h00008000, `AXI_RESP_OKAY);
		wr(`CSUM_VALUE_OFFSET, 32'h1234ABCD, `AXI_RESP_OKAY);
		rd_chk(`CSUM_VALUE_OFFSET, 32'h0000ABCD, `AXI_RESP_OKAY);
		feeder.send(32'h4500003C, 1);
		feeder.send(32'hFFFF8006, 0);
		rd_chk(`CSUM_VALUE_OFFSET, ip_ref(32'h1234ABCD, 32'h4500003C, 32'hFFFF8006),
			`AXI_RESP_OKAY);
	endtask
	// reset in mid-run must clear state that earlier scenarios left behind
	task t_midrst;
		wr(`TAP_MASK_OFFSET, 32'h0000FFFF, `AXI_RESP_OKAY);
		rst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		rd_chk(`CSUM_VALUE_OFFSET, 32'h00000000, `AXI_RESP_OKAY);
		rd_chk(`TAP_MASK_OFFSET, 32'h00000000, `AXI_RESP_OKAY);
		rd_chk(`CSUM_CTRL_OFFSET, 32'h00000000, `AXI_RESP_OKAY);
	endtask

	task wrap_up;
		if (num_errors == 0 && total_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	initial begin
		#200000;
		num_errors++;
		wrap_up();
	end
	initial begin
		num_errors = 0;
		total_checks = 0;
		rst = 1'b1;
		{awvalid, wvalid, arvalid, rready} = 4'h0;
		bready = 1'b1;
		wstrb = 4'hF;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h00000000;
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		t_reset();
		t_regs();
		t_lfsr();
		t_ip();
		t_midrst();
		wrap_up();
	end
endmodule
